//--- logic/uart_ctrl_baud.sv
// serial port control word, deglitch, baud prescaler and modulation with a small frame engine
// assumes an APB master on the system clock and a remote serial node on the line pins
`timescale 1ns/1ns
module uart_ctrl_baud import uart_cfg_pkg::*; (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // serial line
  input wire logic I_RXD,
  output logic O_TXD,
  // interrupt
  output logic O_IRQ
);

  typedef enum {TX_IDLE, TX_GAP, TX_BREAK, TX_DELIM, TX_START, TX_DATA, TX_ADDR, TX_STOP} tx_state_type;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_ADDR, RX_STOP} rx_state_type;

  ctl0_type ctl0_reg;
  mctl_type mctl_reg;
  logic [1:0] glit_reg;
  logic [15:0] brw_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_mask_reg;
  logic [7:0] rxbuf_reg;
  logic [7:0] txbuf_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] read_word;
  logic addr_ok;
  logic commit;
  logic wr_commit;
  logic rd_commit;
  logic hold;
  tx_state_type tx_state_reg;
  logic [21:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_addr_reg;
  logic txd_reg;
  logic tx_done;
  logic tx_launch;
  logic tx_tick;
  logic [21:0] tx_len;
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_s3_reg;
  logic rx_agree_reg;
  logic rx_level;
  logic rx_prev_reg;
  rx_state_type rx_state_reg;
  logic [21:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_addr_bit_reg;
  logic [3:0] rx_idle_bits_reg;
  logic idle_seen_reg;
  logic break_seen_reg;
  logic [21:0] rx_len;
  logic rx_tick;
  logic rx_done;
  logic rx_is_break;
  logic rx_accept;
  logic irq_reg;

  assign hold = ctl0_reg.soft_reset_hold;

  // apb decode; unaligned or unmapped addresses answer with an error
  always_comb begin
    addr_ok = 1'b1;
    read_word = 32'h00000000;
    if (I_PADDR == ADDR_CTLW0) begin
      read_word[CTL0_MODE_LSB +: 2] = ctl0_reg.async_mode_select;
      read_word[CTL0_SLEEP_BIT] = ctl0_reg.receiver_sleep;
      read_word[CTL0_ADDR_BIT] = ctl0_reg.send_address_mark;
      read_word[CTL0_BRK_BIT] = ctl0_reg.send_break;
      read_word[CTL0_HOLD_BIT] = ctl0_reg.soft_reset_hold;
    end else if (I_PADDR == ADDR_CTLW1) begin
      read_word[1:0] = glit_reg;
    end else if (I_PADDR == ADDR_BRW) begin
      read_word[15:0] = brw_reg;
    end else if (I_PADDR == ADDR_MCTLW) begin
      read_word[MCTL_BRS_LSB +: 8] = mctl_reg.second_stage_pattern;
      read_word[MCTL_BRF_LSB +: 4] = mctl_reg.first_stage_pattern;
      read_word[MCTL_OS_BIT] = mctl_reg.oversample_enable;
    end else if (I_PADDR == ADDR_RXBUF) begin
      read_word[7:0] = rxbuf_reg;
    end else if (I_PADDR == ADDR_TXBUF) begin
      read_word[7:0] = txbuf_reg;
    end else if (I_PADDR == ADDR_IRQ_MASK) begin
      read_word[1:0] = irq_mask_reg;
    end else if (I_PADDR == ADDR_IRQ_STATUS) begin
      read_word[1:0] = irq_status_reg;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // one wait state: ready rises in the second access cycle, data and error with it
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= I_PSEL & I_PENABLE & ~pready_reg;
      pslverr_reg <= I_PSEL & I_PENABLE & ~pready_reg & ~addr_ok;
      prdata_reg <= (I_PSEL & I_PENABLE & ~pready_reg & ~I_PWRITE) ? read_word : 32'h00000000;
    end
  end

  assign commit = I_PSEL & I_PENABLE & pready_reg & ~pslverr_reg;
  assign wr_commit = commit & I_PWRITE;
  assign rd_commit = commit & ~I_PWRITE;

  // control word; mode only while held, request bits clear once their frame is launched
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      ctl0_reg <= '{async_mode_select: MODE_PLAIN, receiver_sleep: 1'b0, send_address_mark: 1'b0,
                    send_break: 1'b0, soft_reset_hold: HOLD_RESET};
    end else if (wr_commit && I_PADDR == ADDR_CTLW0) begin
      ctl0_reg.soft_reset_hold <= I_PWDATA[CTL0_HOLD_BIT];
      ctl0_reg.receiver_sleep <= I_PWDATA[CTL0_SLEEP_BIT];
      ctl0_reg.send_address_mark <= I_PWDATA[CTL0_ADDR_BIT];
      ctl0_reg.send_break <= I_PWDATA[CTL0_BRK_BIT];
      if (hold) begin
        ctl0_reg.async_mode_select <= async_mode_type'(I_PWDATA[CTL0_MODE_LSB +: 2]);
      end
    end else if (tx_launch) begin
      ctl0_reg.send_address_mark <= 1'b0;
      ctl0_reg.send_break <= 1'b0;
    end
  end

  // baud words are frozen while the port runs, so a frame never sees a half-changed rate
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      brw_reg <= BRW_RESET;
      mctl_reg <= '0;
      glit_reg <= GLIT_RESET;
    end else if (wr_commit) begin
      if (I_PADDR == ADDR_BRW && hold) begin
        brw_reg <= I_PWDATA[15:0];
      end
      if (I_PADDR == ADDR_MCTLW && hold) begin
        mctl_reg.second_stage_pattern <= I_PWDATA[MCTL_BRS_LSB +: 8];
        mctl_reg.first_stage_pattern <= I_PWDATA[MCTL_BRF_LSB +: 4];
        mctl_reg.oversample_enable <= I_PWDATA[MCTL_OS_BIT];
      end
      if (I_PADDR == ADDR_CTLW1) begin
        glit_reg <= I_PWDATA[1:0];
      end
    end
  end

  // interrupt mask and sticky status; a set in the clearing cycle wins
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_commit && I_PADDR == ADDR_IRQ_STATUS) begin
      irq_status_next = irq_status_next & ~I_PWDATA[1:0];
    end
    if (rd_commit && I_PADDR == ADDR_RXBUF) begin
      irq_status_next[IRQ_RX_BIT] = 1'b0;
    end
    irq_status_next[IRQ_RX_BIT] = irq_status_next[IRQ_RX_BIT] | rx_accept;
    irq_status_next[IRQ_TX_BIT] = irq_status_next[IRQ_TX_BIT] | tx_done;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      irq_mask_reg <= IRQ_RESET;
      irq_status_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
    end else begin
      if (wr_commit && I_PADDR == ADDR_IRQ_MASK) begin
        irq_mask_reg <= I_PWDATA[1:0];
      end
      irq_status_reg <= hold ? IRQ_RESET : irq_status_next;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // transmit: a buffer write while idle launches exactly one frame; writes while busy are dropped
  assign tx_launch = wr_commit && I_PADDR == ADDR_TXBUF && !hold && tx_state_reg == TX_IDLE;
  assign tx_len = bit_cycles(brw_reg, mctl_reg, tx_bit_reg[2:0]);
  assign tx_tick = tx_cnt_reg + 22'h000001 >= tx_len;
  assign tx_done = tx_tick && (tx_state_reg == TX_STOP ||
                   (tx_state_reg == TX_DELIM && ctl0_reg.async_mode_select != MODE_AUTO_BAUD));

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST || hold) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
      tx_addr_reg <= 1'b0;
      txbuf_reg <= '0;
    end else if (tx_launch) begin
      txbuf_reg <= I_PWDATA[7:0];
      tx_shift_reg <= I_PWDATA[7:0];
      tx_addr_reg <= ctl0_reg.send_address_mark;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      if (ctl0_reg.send_break) begin
        tx_state_reg <= TX_BREAK;
      end else if (ctl0_reg.send_address_mark && ctl0_reg.async_mode_select == MODE_IDLE_LINE) begin
        tx_state_reg <= TX_GAP;
      end else begin
        tx_state_reg <= TX_START;
      end
    end else if (tx_state_reg != TX_IDLE) begin
      tx_cnt_reg <= tx_tick ? 22'h000000 : tx_cnt_reg + 22'h000001;
      if (tx_tick) begin
        tx_bit_reg <= tx_bit_reg + 4'h1;
        case (tx_state_reg)
          TX_GAP: begin
            if (tx_bit_reg + 4'h1 == IDLE_BITS) begin
              tx_state_reg <= TX_START;
              tx_bit_reg <= '0;
            end
          end
          TX_BREAK: begin
            if (tx_bit_reg + 4'h1 == BREAK_BITS) begin
              tx_state_reg <= TX_DELIM;
              tx_bit_reg <= '0;
            end
          end
          TX_DELIM: begin
            // auto-baud follows the break with the written synch character
            tx_state_reg <= (ctl0_reg.async_mode_select == MODE_AUTO_BAUD) ? TX_START : TX_IDLE;
            tx_bit_reg <= '0;
          end
          TX_START: begin
            tx_state_reg <= TX_DATA;
            tx_bit_reg <= '0;
          end
          TX_DATA: begin
            if (tx_bit_reg == 4'h7) begin
              tx_state_reg <= (ctl0_reg.async_mode_select == MODE_ADDR_BIT) ? TX_ADDR : TX_STOP;
            end
          end
          TX_ADDR: tx_state_reg <= TX_STOP;
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // line level follows the state one cycle later; idle and held both drive mark
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      txd_reg <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_BREAK: txd_reg <= 1'b0;
        TX_START: txd_reg <= 1'b0;
        TX_DATA: txd_reg <= tx_shift_reg[tx_bit_reg[2:0]];
        TX_ADDR: txd_reg <= tx_addr_reg;
        default: txd_reg <= 1'b1;
      endcase
    end
  end

  // receive pin synchroniser; a change counts once the second and third stages agree
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_agree_reg <= 1'b1;
    end else begin
      rx_s1_reg <= I_RXD;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_agree_reg <= rx_s3_reg;
      end
    end
  end

  rx_deglitch #(.CNT_W(5)) u_deglitch (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_sel(glit_reg),
    .i_level(rx_agree_reg),
    .o_level(rx_level)
  );

  // receive framing; samples the middle of each bit after a half-bit start check
  assign rx_len = bit_cycles(brw_reg, mctl_reg, rx_bit_reg[2:0]);
  assign rx_tick = rx_state_reg == RX_START ? rx_cnt_reg + 22'h000001 >= {1'b0, rx_len[21:1]}
                                            : rx_cnt_reg + 22'h000001 >= rx_len;
  assign rx_done = rx_state_reg == RX_STOP && rx_tick;
  assign rx_is_break = rx_shift_reg == 8'h00 && !rx_level && !rx_addr_bit_reg;

  // flag gating by sleep and mode
  always_comb begin
    rx_accept = 1'b0;
    if (rx_done) begin
      if (!ctl0_reg.receiver_sleep) begin
        rx_accept = 1'b1;
      end else if (ctl0_reg.async_mode_select == MODE_AUTO_BAUD) begin
        rx_accept = break_seen_reg && !rx_is_break && rx_shift_reg == SYNC_CHAR;
      end else begin
        rx_accept = idle_seen_reg || rx_addr_bit_reg;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST || hold) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= '0;
      rx_addr_bit_reg <= 1'b0;
      rx_idle_bits_reg <= '0;
      idle_seen_reg <= 1'b0;
      break_seen_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      rxbuf_reg <= '0;
    end else begin
      rx_prev_reg <= rx_level;
      rx_cnt_reg <= (rx_tick || rx_state_reg == RX_IDLE && !rx_level) ? 22'h000000 : rx_cnt_reg + 22'h000001;
      case (rx_state_reg)
        RX_IDLE: begin
          rx_bit_reg <= '0;
          if (rx_prev_reg && !rx_level) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg <= '0;
          end else if (!rx_level) begin
            rx_idle_bits_reg <= '0;
          end else if (rx_tick && rx_idle_bits_reg != IDLE_BITS) begin
            rx_idle_bits_reg <= rx_idle_bits_reg + 4'h1;
            idle_seen_reg <= idle_seen_reg | (rx_idle_bits_reg + 4'h1 == IDLE_BITS);
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_reg <= rx_level ? RX_IDLE : RX_DATA; // false start returns to idle
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift_reg[rx_bit_reg[2:0]] <= rx_level;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h7) begin
              rx_addr_bit_reg <= 1'b0;
              rx_state_reg <= (ctl0_reg.async_mode_select == MODE_ADDR_BIT) ? RX_ADDR : RX_STOP;
            end
          end
        end
        RX_ADDR: begin
          if (rx_tick) begin
            rx_addr_bit_reg <= rx_level;
            rx_state_reg <= RX_STOP;
          end
        end
        default: begin
          if (rx_tick) begin
            rx_state_reg <= RX_IDLE;
            rx_idle_bits_reg <= '0;
            idle_seen_reg <= 1'b0;
            break_seen_reg <= rx_is_break;
            rxbuf_reg <= rx_shift_reg;
          end
        end
      endcase
    end
  end

  assign O_PRDATA = prdata_reg;
  assign O_PREADY = pready_reg;
  assign O_PSLVERR = pslverr_reg;
  assign O_TXD = txd_reg;
  assign O_IRQ = irq_reg;

  // checks
  a_hold_after_reset: assert property (@(posedge I_SYS_CLK) I_SYS_RST |=> ctl0_reg.soft_reset_hold)
    else $error("soft reset hold not set after reset");
  a_hold_keeps_idle: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    hold |=> ##1 O_TXD && tx_state_reg == TX_IDLE && rx_state_reg == RX_IDLE)
    else $error("port logic active while held");
  a_baud_frozen: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    !hold |=> $stable(brw_reg) && $stable(mctl_reg))
    else $error("baud words changed while running");
  a_glitch_reset: assert property (@(posedge I_SYS_CLK) I_SYS_RST |=> glit_reg == 2'h3 && brw_reg == 16'h0000)
    else $error("deglitch or prescaler reset value wrong");
  a_reserved_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    I_PSEL && I_PENABLE && !pready_reg && I_PADDR == ADDR_MCTLW |=> O_PRDATA[3:1] == 3'h0)
    else $error("reserved modulation bits read nonzero");
  a_request_once: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    tx_launch |=> !ctl0_reg.send_break && !ctl0_reg.send_address_mark)
    else $error("frame request bits not cleared at launch");
  a_break_low: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    tx_launch && ctl0_reg.send_break |=> tx_state_reg == TX_BREAK ##1 !O_TXD)
    else $error("break not driven low");
  a_addr_bit_out: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST || hold)
    tx_state_reg == TX_ADDR |=> O_TXD == tx_addr_reg)
    else $error("address bit not driven");
  a_bit_length: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    !mctl_reg.oversample_enable && brw_reg > 16'h0001 |->
    tx_len == {6'h00, brw_reg} + {21'h000000, mctl_reg.second_stage_pattern[tx_bit_reg[2:0]]})
    else $error("bit length ignores oversample setting");
  a_sleep_gate: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST || hold)
    rx_done && ctl0_reg.receiver_sleep && ctl0_reg.async_mode_select != MODE_AUTO_BAUD &&
    !idle_seen_reg && !rx_addr_bit_reg |-> !rx_accept)
    else $error("sleeping receiver flagged unqualified character");
  a_autobaud_gate: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST || hold)
    rx_accept && ctl0_reg.receiver_sleep && ctl0_reg.async_mode_select == MODE_AUTO_BAUD |->
    break_seen_reg ##1 irq_status_reg[IRQ_RX_BIT])
    else $error("auto-baud flag without break and synch");
  c_frame_sent: cover property (@(posedge I_SYS_CLK) tx_done);
  c_break_sent: cover property (@(posedge I_SYS_CLK) tx_state_reg == TX_BREAK ##1 tx_state_reg == TX_DELIM);
  c_char_taken: cover property (@(posedge I_SYS_CLK) rx_accept);
  c_irq_raised: cover property (@(posedge I_SYS_CLK) $rose(O_IRQ));

endmodule

//--- logic/uart_cfg_pkg.sv
// shared constants, types and helpers of the serial port control and baud block
// assumes a 100 MHz system clock and a register bus with word-aligned registers
package uart_cfg_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 10;

  // register indexes; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_CTLW0 = 8'h00;
  localparam logic [7:0] IDX_CTLW1 = 8'h02;
  localparam logic [7:0] IDX_BRW = 8'h06;
  localparam logic [7:0] IDX_MCTLW = 8'h08;
  localparam logic [7:0] IDX_RXBUF = 8'h0C;
  localparam logic [7:0] IDX_TXBUF = 8'h0E;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1A;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_CTLW0 = 8'(IDX_CTLW0 * 4);
  localparam logic [7:0] ADDR_CTLW1 = 8'(IDX_CTLW1 * 4);
  localparam logic [7:0] ADDR_BRW = 8'(IDX_BRW * 4);
  localparam logic [7:0] ADDR_MCTLW = 8'(IDX_MCTLW * 4);
  localparam logic [7:0] ADDR_RXBUF = 8'(IDX_RXBUF * 4);
  localparam logic [7:0] ADDR_TXBUF = 8'(IDX_TXBUF * 4);
  localparam logic [7:0] ADDR_IRQ_MASK = 8'(IDX_IRQ_MASK * 4);
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'(IDX_IRQ_STATUS * 4);

  // field positions
  localparam int CTL0_HOLD_BIT = 0;
  localparam int CTL0_BRK_BIT = 1;
  localparam int CTL0_ADDR_BIT = 2;
  localparam int CTL0_SLEEP_BIT = 3;
  localparam int CTL0_MODE_LSB = 9;
  localparam int MCTL_OS_BIT = 0;
  localparam int MCTL_BRF_LSB = 4;
  localparam int MCTL_BRS_LSB = 8;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;

  // reset values
  localparam logic HOLD_RESET = 1'h1;
  localparam logic [1:0] GLIT_RESET = 2'h3;
  localparam logic [15:0] BRW_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // deglitch times and their cycle counts (rounded down, at least one cycle)
  localparam int GLITCH_NS_0 = 2;
  localparam int GLITCH_NS_1 = 50;
  localparam int GLITCH_NS_2 = 100;
  localparam int GLITCH_NS_3 = 200;
  localparam int GLITCH_CYC_0 = (GLITCH_NS_0 / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS_0 / CLK_PERIOD_NS;
  localparam int GLITCH_CYC_1 = (GLITCH_NS_1 / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS_1 / CLK_PERIOD_NS;
  localparam int GLITCH_CYC_2 = (GLITCH_NS_2 / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS_2 / CLK_PERIOD_NS;
  localparam int GLITCH_CYC_3 = (GLITCH_NS_3 / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS_3 / CLK_PERIOD_NS;

  // line framing counts, in bit periods, and the auto-baud synch character
  localparam logic [3:0] IDLE_BITS = 4'hA;
  localparam logic [3:0] BREAK_BITS = 4'hD;
  localparam logic [7:0] SYNC_CHAR = 8'h55;

  typedef enum logic [1:0] {MODE_PLAIN, MODE_IDLE_LINE, MODE_ADDR_BIT, MODE_AUTO_BAUD} async_mode_type;

  typedef struct packed {
    async_mode_type async_mode_select;
    logic receiver_sleep;
    logic send_address_mark;
    logic send_break;
    logic soft_reset_hold;
  } ctl0_type;

  typedef struct packed {
    logic [7:0] second_stage_pattern;
    logic [3:0] first_stage_pattern;
    logic oversample_enable;
  } mctl_type;

  // source clocks in one bit period; a zero divisor acts as one
  function automatic logic [21:0] bit_cycles(input logic [15:0] div, input mctl_type m, input logic [2:0] idx);
    logic [21:0] d;
    d = (div == 16'h0000) ? 22'h000001 : {6'h00, div};
    if (m.oversample_enable) begin
      d = {d[17:0], 4'h0} + {18'h00000, m.first_stage_pattern};
    end
    return d + {21'h000000, m.second_stage_pattern[idx]};
  endfunction

endpackage

//--- logic/rx_deglitch.sv
// receive line glitch filter with a selectable suppression time
// assumes its input is already synchronised to the system clock
`timescale 1ns/1ns
module rx_deglitch import uart_cfg_pkg::*; #(
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic [1:0] i_sel,
  // line
  input wire logic i_level,
  output logic o_level
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;
  logic level_reg;

  // the counter must reach the longest suppression time
  if ((2 ** CNT_W) <= GLITCH_CYC_3) begin : g_bad_width
    $error("rx_deglitch: CNT_W too small for the longest filter time");
  end

  // filter length per selection
  always_comb begin
    case (i_sel)
      2'h0: limit = CNT_W'(GLITCH_CYC_0);
      2'h1: limit = CNT_W'(GLITCH_CYC_1);
      2'h2: limit = CNT_W'(GLITCH_CYC_2);
      default: limit = CNT_W'(GLITCH_CYC_3);
    endcase
  end

  // a new level is taken only after it held for the whole filter time
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_reg <= 1'b1;
      count_reg <= '0;
    end else if (i_level == level_reg) begin
      count_reg <= '0;
    end else if (count_reg + CNT_W'(1) >= limit) begin
      level_reg <= i_level;
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  assign o_level = level_reg;

endmodule

//--- dv/serial_node.sv
// remote serial node driving the port's receive line
// assumes the bench gives the bit length in clocks
`timescale 1ns/1ns
module serial_node (
  input wire logic i_clk,
  output logic o_line
);
  // line rests high between frames
  initial o_line = 1'h1;
  // start, eight bits lsb first, stop
  task automatic send(input logic [7:0] ch, input int len);
    logic [9:0] fr;
    fr = {1'h1, ch, 1'h0};
    for (int i = 0; i < 10; i++) begin
      o_line <= fr[i];
      repeat (len) @(posedge i_clk);
    end
  endtask
  // break: line low for longer than a whole frame, then one bit of mark before the next frame
  task automatic brk(input int len);
    o_line <= 1'h0;
    repeat (14 * len) @(posedge i_clk);
    o_line <= 1'h1;
    repeat (len) @(posedge i_clk);
  endtask
endmodule

//--- dv/uart_ctrl_baud_test.sv
// bench: registers over apb, a tx frame, a break and an rx character
// assumes one apb wait state and a divisor of 4
`timescale 1ns/1ns
module uart_ctrl_baud_test;
  import uart_cfg_pkg::*;
  localparam int L = 4; // clocks per bit for divisor 4
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, err, rxd, txd, irq;
  logic [9:0] f;
  int error_cnt = 0;
  int comparisons = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  serial_node node (.i_clk(clk), .o_line(rxd));
  uart_ctrl_baud dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_RXD(rxd), .O_TXD(txd), .O_IRQ(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    // one idle edge, so a following call never re-drives psel in the same step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  // bounded wait for a start bit, then sample ten bit middles
  task automatic grab;
    for (int n = 0; txd !== 1'h0 && n < 400; n++) @(posedge clk);
    repeat (L / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      repeat (L) @(posedge clk);
    end
  endtask
  task automatic t_reset;
    rd(ADDR_CTLW0, 32'h1);
    rd(ADDR_CTLW1, 32'h3);
    rd(ADDR_BRW, 32'h0);
    rd(ADDR_MCTLW, 32'h0);
    rd(8'h04, 32'h0);
    chk(err, 32'h1);
    $display("reset test done");
  endtask
  // baud words are written only while held, then locked
  task automatic t_cfg;
    wr(ADDR_CTLW1, 32'hFFFF);
    rd(ADDR_CTLW1, 32'h3);
    wr(ADDR_MCTLW, 32'hFFFF);
    rd(ADDR_MCTLW, 32'hFFF1);
    wr(ADDR_BRW, 32'h4);
    rd(ADDR_BRW, 32'h4);
    wr(ADDR_MCTLW, 32'h0);
    wr(ADDR_CTLW1, 32'h0);
    wr(ADDR_CTLW0, 32'h0);
    wr(ADDR_BRW, 32'h9);
    rd(ADDR_BRW, 32'h4);
    rd(ADDR_CTLW1, 32'h0);
    $display("config test done");
  endtask
  task automatic t_tx;
    wr(ADDR_IRQ_MASK, 32'h2);
    wr(ADDR_TXBUF, 32'hA5);
    grab;
    chk(f, 32'h34A);
    repeat (L + 4) @(posedge clk);
    chk(irq, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h2);
    rd(ADDR_IRQ_STATUS, 32'h0);
    chk(irq, 32'h0);
    $display("tx test done");
  endtask
  task automatic t_brk;
    wr(ADDR_CTLW0, 32'h2);
    wr(ADDR_TXBUF, 32'h0);
    grab;
    chk(f, 32'h0);
    rd(ADDR_CTLW0, 32'h0);
    repeat (8 * L) @(posedge clk);
    $display("break test done");
  endtask
  // rx is masked, so the line must stay low
  task automatic t_rx;
    wr(ADDR_IRQ_STATUS, 32'h3);
    node.send(8'h3C, L);
    repeat (10) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'h1);
    chk(irq, 32'h0);
    rd(ADDR_RXBUF, 32'h3C);
    rd(ADDR_IRQ_STATUS, 32'h0);
    $display("rx test done");
  endtask
  // sleeping receiver flags only a character that follows an idle line
  task automatic t_sleep;
    wr(ADDR_CTLW0, 32'h8);
    repeat (12 * L) @(posedge clk);
    node.send(8'h11, L);
    repeat (10) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'h1);
    rd(ADDR_RXBUF, 32'h11);
    node.send(8'h22, L);
    repeat (10) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'h0);
    rd(ADDR_RXBUF, 32'h22);
    $display("sleep test done");
  endtask
  // auto-baud: break then synch out; a sleeping receiver wakes only on break plus synch
  task automatic t_auto;
    wr(ADDR_CTLW0, 32'h1);
    wr(ADDR_CTLW0, 32'h601);
    wr(ADDR_CTLW0, 32'h60A);
    wr(ADDR_TXBUF, 32'h55);
    grab;
    chk(f, 32'h0);
    repeat (3 * L) @(posedge clk);
    grab;
    chk(f, 32'h2AA);
    rd(ADDR_CTLW0, 32'h608);
    wr(ADDR_IRQ_STATUS, 32'h3);
    node.brk(L);
    rd(ADDR_IRQ_STATUS, 32'h0);
    node.send(8'h55, L);
    repeat (10) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'h1);
    $display("auto-baud test done");
  endtask
  // address-bit mode: the marked frame carries a ninth bit of one
  task automatic t_addr;
    wr(ADDR_CTLW0, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h0);
    wr(ADDR_CTLW0, 32'h401);
    wr(ADDR_CTLW0, 32'h404);
    wr(ADDR_TXBUF, 32'h5A);
    grab;
    chk(f, 32'h2B4);
    rd(ADDR_CTLW0, 32'h400);
    $display("address test done");
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence after 20 reset cycles
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset;
    t_cfg;
    t_tx;
    t_brk;
    t_rx;
    t_sleep;
    t_auto;
    t_addr;
    wrap_up;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
endmodule
